// file: hdl/srilc_top.sv
// Reset, interrupt and low-power sequencer logic
`timescale 1ns/1ps
// How it works
// - Brownout sets flag, pin low 4096, reset 4096+64
// - Every internal reset drives pin low
// - 13-bit prescaler, falling reference edge, overflow
// - Pin reset keeps prescaler, free-running outside stop
// - Entry stacks registers and sets mask
// - Latched interrupt holds until serviced
// - Service after instruction, unmasked and enabled
// - Highest priority pending serviced first
// - Pending after return serviced before next
// - High index byte never stacked
// - Software trap ignores the mask
// - Resets equal priority, above interrupts
// - Wait stops core clock, clears mask
// - Wait keeps peripherals; interrupt/reset exits
// - Wake stacking starts one cycle later
// - Watchdog runs in wait when enabled
// - Stop clears prescaler, gates clocks, 4096
// - Interrupt, reset, break end stop
// - Break ends wait sets flag; write 0
// - Reset-cause flags, read clears all
// - Power-on sets only power-on flag
// - Bad address only on opcode fetch
// - Service write clears prescaler bits 12-4
module srilc_top
  import srilc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic osc_reference_clock,
  input wire logic por_pulse,
  input wire logic brownout_req,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic wdog_timeout,
  input wire logic bad_opcode,
  input wire logic opcode_fetch,
  input wire logic fetch_unimpl,
  input wire logic erased_vector,
  input wire logic watchdog_disable_bit,
  input wire logic [srilc_pkg::SRILC_NIRQ-1:0] irq_req,
  input wire logic [srilc_pkg::SRILC_NIRQ-1:0] irq_en,
  input wire logic insn_done,
  input wire logic software_trap_instruction,
  input wire logic interrupt_return_instruction,
  input wire logic wait_insn,
  input wire logic stop_insn,
  input wire logic break_req,
  input wire logic stack_done,
  input wire logic mask_bit,
  output logic mask_set,
  output logic mask_clear,
  output logic stack_start,
  output logic stack_high_index,
  output logic [3:0] irq_vector,
  output logic chip_reset_signal,
  output logic core_clock_en,
  output logic internal_bus_clocks,
  output logic core_clock_source,
  output logic wdog_clock,
  output logic wdog_run,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import srilc_pkg::*;

  // ==========================================================
  // Pin synchronisers and reference edge
  logic [1:0] pin_s_r, osc_s_r;
  logic [1:0] oe_q_r;
  logic osc_d_r;
  logic pin_low;
  logic osc_fall;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_s_r <= 2'h3;
      oe_q_r <= 2'h3;
      osc_s_r <= 2'h0;
      osc_d_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s_r <= {pin_s_r[0], reset_pin_in};
      oe_q_r <= {oe_q_r[0], reset_pin_oe};
      osc_s_r <= {osc_s_r[0], osc_reference_clock};
      osc_d_r <= osc_s_r[1];
    end
  end
  // Own drive and its echo through the synchroniser are not an external reset
  assign pin_low = !pin_s_r[1] && !reset_pin_oe && !(|oe_q_r);
  assign osc_fall = osc_d_r && !osc_s_r[1];

  // ==========================================================
  // State machine
  srilc_state_e state_r, state_nxt;
  logic [SRILC_CNT_W-1:0] seq_cnt_r;
  logic long_seq_r;
  logic drive_r;
  logic int_rst;
  logic any_rst;
  logic [SRILC_NIRQ-1:0] pend;
  logic latched_r;
  logic [3:0] vec_r;
  logic seq_end;
  logic [SRILC_PRE_W-1:0] pre_r;
  logic pre_ovf;

  // Lowest index wins: index 0 is the highest priority source
  function automatic logic [3:0] prio_pick(input logic [SRILC_NIRQ-1:0] p);
    logic [3:0] v;
    v = 4'h0;
    for (int i = SRILC_NIRQ - 1; i >= 0; i--)
      if (p[i])
        v = 4'(i);
    return v;
  endfunction

  assign int_rst = por_pulse | brownout_req | wdog_timeout | bad_opcode
                 | (opcode_fetch & fetch_unimpl) | erased_vector;
  assign any_rst = int_rst | pin_low;
  assign pend = irq_req & irq_en;
  assign seq_end = osc_fall && (seq_cnt_r == (long_seq_r ?
                   SRILC_CNT_W'(SRILC_STARTUP_CYC + SRILC_RELEASE_CYC - 1) :
                   SRILC_CNT_W'(2 * SRILC_PIN_DRIVE_CYC - 1)));

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SRILC_RUN:
      begin
        if (insn_done && (software_trap_instruction || (!mask_bit && |pend)))
          state_nxt = SRILC_STACK;
        else if (insn_done && wait_insn)
          state_nxt = SRILC_WAIT;
        else if (insn_done && stop_insn)
          state_nxt = SRILC_STOP;
      end
      SRILC_STACK:
        if (stack_done)
          state_nxt = SRILC_RUN;
      SRILC_WAIT:
        if (|pend || break_req)
          state_nxt = SRILC_STACK;
      SRILC_STOP:
        if (|pend || break_req)
          state_nxt = SRILC_STOPREC;
      SRILC_STOPREC:
        if (pre_r == SRILC_PRE_W'(SRILC_STOP_REC_CYC - 1) && osc_fall)
          state_nxt = SRILC_STACK;
      SRILC_RSTSEQ:
        if (seq_end)
          state_nxt = SRILC_RUN;
      default:
        state_nxt = SRILC_RSTSEQ;
    endcase
    if (any_rst)
      state_nxt = SRILC_RSTSEQ;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= SRILC_RSTSEQ;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // ==========================================================
  // Reset sequence timing
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seq_cnt_r <= '0;
      long_seq_r <= 1'b1;
      drive_r <= 1'b1;
    end
    else if (clk_en)
    begin
      if (int_rst)
      begin
        seq_cnt_r <= '0;
        long_seq_r <= por_pulse | brownout_req;
        drive_r <= 1'b1;
      end
      else if (pin_low)
      begin
        seq_cnt_r <= '0;
        long_seq_r <= 1'b0;
        drive_r <= 1'b0;
      end
      else if (state_r == SRILC_RSTSEQ && osc_fall)
        seq_cnt_r <= seq_cnt_r + 1'b1;
    end
  end

  // Pin is driven while an internal reset source is active or an internal sequence is in its drive phase
  always_comb
  begin
    reset_pin_out = 1'b0;
    reset_pin_oe = 1'b0;
    if (state_r == SRILC_RSTSEQ && drive_r && long_seq_r)
      reset_pin_oe = seq_cnt_r < SRILC_CNT_W'(SRILC_STARTUP_CYC);
    else if (state_r == SRILC_RSTSEQ && drive_r)
      reset_pin_oe = seq_cnt_r < SRILC_CNT_W'(SRILC_PIN_DRIVE_CYC);
    if (int_rst)
      reset_pin_oe = 1'b1;
  end

  assign chip_reset_signal = state_r == SRILC_RSTSEQ;
  assign core_clock_en = state_r != SRILC_WAIT && state_r != SRILC_STOP
                      && state_r != SRILC_STOPREC && !chip_reset_signal;
  assign internal_bus_clocks = state_r != SRILC_STOP && state_r != SRILC_STOPREC
                            && !(chip_reset_signal && long_seq_r
                            && seq_cnt_r < SRILC_CNT_W'(SRILC_STARTUP_CYC));
  assign core_clock_source = state_r != SRILC_STOP;

  // ==========================================================
  // Prescaler
  logic svc_wr;
  assign svc_wr = reg_wr && reg_addr == SRILC_OFF_WDSVC;
  assign pre_ovf = osc_fall && (&pre_r);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pre_r <= SRILC_PRE_RST;
    else if (clk_en)
    begin
      if (state_r == SRILC_STOP)
        pre_r <= SRILC_PRE_RST;
      else if (int_rst && !(state_r == SRILC_RSTSEQ))
        pre_r <= SRILC_PRE_RST;
      else if (svc_wr)
        pre_r <= pre_r & SRILC_PRE_SVC_MASK;
      else if (osc_fall)
        pre_r <= pre_r + 1'b1;
    end
  end

  // Overflow pulse drives the watchdog, also in wait
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wdog_clock <= 1'b0;
    else if (clk_en)
      wdog_clock <= pre_ovf && !watchdog_disable_bit;
  end
  assign wdog_run = !watchdog_disable_bit && state_r != SRILC_STOP;

  // ==========================================================
  // Interrupt latch and arbitration
  logic entering;
  assign entering = state_r != SRILC_STACK && state_nxt == SRILC_STACK;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      latched_r <= 1'b0;
      vec_r <= 4'h0;
    end
    else if (clk_en)
    begin
      if (any_rst)
        latched_r <= 1'b0;
      else if (entering && !latched_r)
      begin
        latched_r <= 1'b1;
        vec_r <= (state_r == SRILC_RUN && software_trap_instruction) ?
                 SRILC_SWI_VEC : prio_pick(pend);
      end
      else if (stack_done || (latched_r && !mask_bit && state_r == SRILC_RUN))
        latched_r <= 1'b0;
    end
  end
  assign irq_vector = vec_r;

  // Stacking pulse comes the cycle after entry is decided, also after wait
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stack_start <= 1'b0;
    else if (clk_en)
      stack_start <= entering && !any_rst;
  end
  assign mask_set = stack_done;
  assign mask_clear = state_r == SRILC_RUN && insn_done && wait_insn;
  assign stack_high_index = 1'b0;
  // A return leaves RUN with insn_done; pending work re-enters STACK directly
  logic unused_rti;
  assign unused_rti = interrupt_return_instruction;

  // ==========================================================
  // Registers
  logic [7:0] rstc_r, brk_r;
  logic rd_rstc;
  assign rd_rstc = reg_rd && reg_addr == SRILC_OFF_RSTC;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rstc_r <= SRILC_RSTC_RST;
    else if (clk_en)
    begin
      if (por_pulse)
        rstc_r <= SRILC_RSTC_RST;
      else if (any_rst)
      begin
        rstc_r <= rd_rstc ? 8'h00 : rstc_r;
        if (brownout_req)
          rstc_r[SRILC_F_LVI] <= 1'b1;
        if (erased_vector)
          rstc_r[SRILC_F_MEN] <= 1'b1;
        if (opcode_fetch && fetch_unimpl)
          rstc_r[SRILC_F_BAD_FETCH_ADDRESS_FLAG] <= 1'b1;
        if (bad_opcode)
          rstc_r[SRILC_F_BAD_OPCODE_FLAG] <= 1'b1;
        if (wdog_timeout)
          rstc_r[SRILC_F_WDOG] <= 1'b1;
        if (pin_low && !brownout_req)
          rstc_r[SRILC_F_PIN] <= 1'b1;
      end
      else if (rd_rstc)
        rstc_r <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      brk_r <= SRILC_BRK_RST;
    else if (clk_en)
    begin
      if (any_rst)
        brk_r <= SRILC_BRK_RST;
      else if (state_r == SRILC_WAIT && break_req)
        brk_r[SRILC_BRK_BIT] <= 1'b1;
      else if (reg_wr && reg_addr == SRILC_OFF_BRK && !reg_wdata[SRILC_BRK_BIT])
        brk_r[SRILC_BRK_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata <= 8'h00;
      if (reg_rd && reg_addr == SRILC_OFF_BRK)
        reg_rdata <= brk_r;
      else if (rd_rstc)
        reg_rdata <= rstc_r;
    end
  end
endmodule

// file: inc/srilc_pkg.sv
// Package for the reset, interrupt and low-power sequencer
package srilc_pkg;
  localparam int SRILC_CLK_NS = 25;
  localparam int SRILC_PRE_W = 13;
  localparam logic [12:0] SRILC_PRE_RST = 13'h0000;
  localparam logic [12:0] SRILC_PRE_SVC_MASK = 13'h000F;
  localparam int SRILC_STARTUP_CYC = 4096;
  localparam int SRILC_RELEASE_CYC = 64;
  localparam int SRILC_PIN_DRIVE_CYC = 32;
  localparam int SRILC_STOP_REC_CYC = 4096;
  localparam int SRILC_CNT_W = 13;
  localparam int SRILC_NIRQ = 8;
  localparam logic [3:0] SRILC_OFF_BRK = 4'h0;
  localparam logic [3:0] SRILC_OFF_RSTC = 4'h1;
  localparam logic [3:0] SRILC_OFF_WDSVC = 4'h2;
  localparam int SRILC_BRK_BIT = 1;
  localparam int SRILC_F_LVI = 1;
  localparam int SRILC_F_MEN = 2;
  localparam int SRILC_F_BAD_FETCH_ADDRESS_FLAG = 3;
  localparam int SRILC_F_BAD_OPCODE_FLAG = 4;
  localparam int SRILC_F_WDOG = 5;
  localparam int SRILC_F_PIN = 6;
  localparam int SRILC_F_POR = 7;
  localparam logic [7:0] SRILC_RSTC_RST = 8'h80;
  localparam logic [7:0] SRILC_BRK_RST = 8'h00;
  localparam logic [3:0] SRILC_SWI_VEC = 4'hF;
  typedef enum logic [5:0] {
    SRILC_RUN = 6'h01,
    SRILC_RSTSEQ = 6'h02,
    SRILC_STACK = 6'h04,
    SRILC_WAIT = 6'h08,
    SRILC_STOP = 6'h10,
    SRILC_STOPREC = 6'h20
  } srilc_state_e;
endpackage

// file: verification/srilc_core_model.sv
// Core-side model: answers stacking requests and holds the interrupt mask
`timescale 1ns/1ps
module srilc_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] lat,
  input wire logic stack_start,
  input wire logic mask_set,
  input wire logic mask_clear,
  input wire logic ret,
  output logic stack_done,
  output logic mask_bit
);
  logic [4:0] cnt_r;
  // ==========
  // Stacking, prompt or slow as lat asks
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= '0;
      stack_done <= 1'b0;
    end
    else
    begin
      stack_done <= (cnt_r == 5'h01);
      if (stack_start)
        cnt_r <= {1'b0, lat} + 5'h01;
      else if (cnt_r != 5'h00)
        cnt_r <= cnt_r - 5'h01;
    end
  end
  // Mask comes up set so no interrupt request is taken before software allows it; a software trap still is
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mask_bit <= 1'b1;
    else if (mask_set)
      mask_bit <= 1'b1;
    else if (mask_clear || ret)
      mask_bit <= 1'b0;
  end
endmodule

// file: verification/srilc_top_asserts.sv
// Port-level checks for the sequencer
`timescale 1ns/1ps
module srilc_top_asserts
  import srilc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reset_pin_oe,
  input wire logic bad_opcode,
  input wire logic stack_done,
  input wire logic mask_set,
  input wire logic stack_start,
  input wire logic stack_high_index,
  input wire logic [3:0] irq_vector,
  input wire logic insn_done,
  input wire logic software_trap_instruction,
  input wire logic wait_insn,
  input wire logic mask_bit,
  input wire logic mask_clear,
  input wire logic core_clock_en,
  input wire logic internal_bus_clocks,
  input wire logic chip_reset_signal,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_rdata
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==========
  // Checks
  a_int_pin_drive: assert property (bad_opcode |-> ##[1:8] reset_pin_oe)
    else $error("pin not driven");
  a_mask_on_entry: assert property (stack_start |-> ##[1:20] mask_set)
    else $error("mask not set");
  a_no_hi_stack: assert property (!stack_high_index)
    else $error("high index stacked");
  a_trap_vector: assert property (insn_done && software_trap_instruction && mask_bit
    |-> ##[1:2] (stack_start && irq_vector == SRILC_SWI_VEC)) else $error("trap lost");
  a_masked_hold: assert property (insn_done && mask_bit && !software_trap_instruction
    && !wait_insn |=> !stack_start [*3]) else $error("masked taken");
  a_wait_mask_clr: assert property (insn_done && wait_insn |-> ##[0:1] mask_clear)
    else $error("mask kept");
  a_wait_clocks: assert property (insn_done && wait_insn
    |-> ##[1:2] (!core_clock_en && internal_bus_clocks)) else $error("wait clocks");
  a_rc_read_clear: assert property ((reg_rd && reg_addr == SRILC_OFF_RSTC)
    ##1 !chip_reset_signal ##1 (!chip_reset_signal && reg_rd && reg_addr == SRILC_OFF_RSTC)
    |=> reg_rdata == 8'h00) else $error("cause kept");
  c_stack: cover property (stack_start);
  c_wait: cover property (!core_clock_en && internal_bus_clocks);
  c_reset: cover property ($fell(chip_reset_signal));
endmodule

bind srilc_top srilc_top_asserts u_chk (.*);

// file: verification/srilc_top_bench.sv
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module srilc_top_bench;
  import srilc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] dv = '0;
  logic [5:0] src = '0;
  logic unimpl = 1'b0, brk = 1'b0, idone = 1'b0, trap = 1'b0, wt = 1'b0, ret = 1'b0;
  logic rd = 1'b0, wr = 1'b0, stp = 1'b0;
  logic [7:0] req = '0, en = '0, wd = '0, d, p;
  logic [3:0] addr = '0, lat = '0, ex;
  logic [31:0] seed = 32'hE58E5D5B;
  int failures = 0, samples_checked = 0, n, g;
  int oref [6] = '{32, 32, 32, 32, 0, 4096};
  int gref [6] = '{32, 32, 32, 32, 0, 64};
  int fbit [6] = '{SRILC_F_BAD_OPCODE_FLAG, SRILC_F_MEN, SRILC_F_WDOG, SRILC_F_BAD_FETCH_ADDRESS_FLAG, SRILC_F_PIN, SRILC_F_LVI};
  wire logic oe, sdone, mset, mclr, sst, crst, cce, ibc, mbit, ccs, wrun;
  wire logic [3:0] vec;
  wire logic [7:0] rdata;
  // Pin is pulled up; low while the device or the bench pulls it
  srilc_top DUT (.clk(clk), .resetn(resetn), .clk_en(1'b1), .osc_reference_clock(dv[1]),
    .por_pulse(1'b0), .brownout_req(src[5]), .reset_pin_in(~(oe | src[4])), .reset_pin_out(),
    .reset_pin_oe(oe), .wdog_timeout(src[2]), .bad_opcode(src[0]), .opcode_fetch(src[3]),
    .fetch_unimpl(src[3] | unimpl), .erased_vector(src[1]), .watchdog_disable_bit(1'b0),
    .irq_req(req), .irq_en(en), .insn_done(idone), .software_trap_instruction(trap),
    .interrupt_return_instruction(ret), .wait_insn(wt), .stop_insn(stp), .break_req(brk),
    .stack_done(sdone), .mask_bit(mbit), .mask_set(mset), .mask_clear(mclr), .stack_start(sst),
    .stack_high_index(), .irq_vector(vec), .chip_reset_signal(crst), .core_clock_en(cce),
    .internal_bus_clocks(ibc), .core_clock_source(ccs), .wdog_clock(), .wdog_run(wrun),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
  srilc_core_model core (.clk(clk), .resetn(resetn), .lat(lat), .stack_start(sst),
    .mask_set(mset), .mask_clear(mclr), .ret(ret), .stack_done(sdone), .mask_bit(mbit));
  // ==========
  // Clocks and watchdog
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) dv <= dv + 2'h1;
  initial
  begin
    #(25 * 90000);
    failures++;
    wrap_up();
  end
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [3:0] top_irq(input logic [7:0] q);
    top_irq = 4'h0;
    for (int i = 7; i >= 0; i--)
      if (q[i])
        top_irq = i[3:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    v = rdata;
    cyc(1);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic insn(input logic t, input logic w);
    trap <= t;
    wt <= w;
    idone <= 1'b1;
    cyc(1);
    trap <= 1'b0;
    wt <= 1'b0;
    idone <= 1'b0;
  endtask
  task automatic wstack;
    for (int i = 0; i < 24 && sst !== 1'b1; i++)
      cyc(1);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  initial
  begin
    cyc(4);
    resetn <= 1'b1;
    rreg(SRILC_OFF_RSTC, d);
    check(d, SRILC_RSTC_RST);
    check(oe, 1'b1);
    for (int i = 0; i < 20000 && crst !== 1'b0; i++)
      cyc(1);
    rreg(SRILC_OFF_RSTC, d);
    unimpl <= 1'b1;
    cyc(8);
    unimpl <= 1'b0;
    check(crst, 1'b0);
    for (int t = 0; t < 8; t++)
    begin
      seed = xs(seed);
      p = seed[7:0] | 8'h80;
      req <= p;
      en <= seed[15:8] | 8'h80;
      lat <= seed[19:16];
      ex = top_irq(p & (seed[15:8] | 8'h80));
      ret <= 1'b1;
      cyc(1);
      ret <= 1'b0;
      insn(1'b0, 1'b0);
      req <= 8'h01;
      wstack();
      check(sst, 1'b1);
      check(vec, ex);
      cyc(20);
    end
    insn(1'b1, 1'b0);
    wstack();
    check(vec, SRILC_SWI_VEC);
    cyc(20);
    en <= 8'hFF;
    insn(1'b0, 1'b0);
    n = 0;
    repeat (4)
    begin
      cyc(1);
      n += sst;
    end
    check(n[7:0], 8'h00);
    req <= 8'h00;
    insn(1'b0, 1'b1);
    cyc(1);
    check(cce, 1'b0);
    check(ibc, 1'b1);
    check(mbit, 1'b0);
    check(wrun, 1'b1);
    req <= 8'h04;
    wstack();
    check(vec, 4'h2);
    cyc(20);
    req <= 8'h00;
    insn(1'b0, 1'b1);
    brk <= 1'b1;
    cyc(8);
    brk <= 1'b0;
    rreg(SRILC_OFF_BRK, d);
    check(d[SRILC_BRK_BIT], 1'b1);
    wreg(SRILC_OFF_BRK, 8'h00);
    wreg(4'hA, 8'hFF);
    rreg(4'hA, d);
    check(d, 8'h00);
    rreg(SRILC_OFF_BRK, d);
    check(d, 8'h00);
    // Stop, then a module interrupt wakes it after the full recovery delay
    cyc(4);
    stp <= 1'b1;
    insn(1'b0, 1'b0);
    stp <= 1'b0;
    cyc(1);
    check({ccs, ibc, wrun}, 3'h0);
    req <= 8'h08;
    for (n = 0; n < 20000 && sst !== 1'b1; n++)
      cyc(1);
    check(n > 4 * SRILC_STOP_REC_CYC - 16 && n < 4 * SRILC_STOP_REC_CYC + 16, 1'b1);
    check(vec, 4'h3);
    cyc(20);
    req <= 8'h00;
    wreg(SRILC_OFF_WDSVC, 8'h5A);
    for (int k = 0; k < 6; k++)
    begin
      n = 0;
      g = 0;
      src <= 6'h01 << k;
      cyc(k == 4 ? 400 : 4);
      src <= '0;
      for (int i = 0; i < 20000 && crst !== 1'b0; i++)
      begin
        cyc(1);
        n += oe;
        g += !oe && crst;
      end
      if (oref[k] != 0)
      begin
        check(n > 4 * oref[k] - 16 && n < 4 * oref[k] + 16, 1'b1);
        check(g > 4 * gref[k] - 16 && g < 4 * gref[k] + 16, 1'b1);
      end
      rreg(SRILC_OFF_RSTC, d);
      check(d, 8'h01 << fbit[k]);
      rreg(SRILC_OFF_RSTC, d);
      check(d, 8'h00);
    end
    wrap_up();
  end
endmodule
